// [idt_pkg.sv]
// How it works
// - instruction words are exactly fourteen bits
// - sort words into byte, bit, literal/control
// - one instruction cycle unless listed exception
// - both subroutine calls take two cycles
// - all three returns take two cycles
// - jumps, branches, taken skips take two cycles
// - indirect access to program memory adds cycle
// - instruction cycle is four oscillator periods
// - file writes read, modify, then write back
// - file address field spans 0x00 to 0x7f
// - bit field picks one of eight bits
// - destination bit 0 selects W, 1 file
// - don't-care bits never change decoding
// - pointer index selects pointer pair 0 or 1
// - two-bit mode selects pre/post inc/dec
// - literal field used as constant or target
// - flow change second cycle runs as no-operation
// - extra cycle when selected pointer msb set
// - destination at bit 7 above address 6:0
package idt_pkg;
    localparam int          INSTR_W       = 14;
    localparam int          FILE_ADDR_W   = 7;
    localparam logic [6:0]  FILE_ADDR_MAX = 7'h7f;
    localparam int          DATA_W        = 8;
    localparam int          LIT_W         = 11;
    localparam int          OSC_PER_CYC   = 4;
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          DEST_POS      = 7;
    localparam int          BIT_LSB       = 7;
    localparam int          PTR_IDX_SHORT = 2;
    localparam int          PTR_IDX_LONG  = 6;
    localparam int          PH_READ       = 1;
    localparam int          PH_MODIFY     = 2;
    localparam int          PH_WRITE      = 3;
    localparam logic [13:0] INSTR_RST     = 14'h0000;
    localparam logic [1:0]  CYC_RST       = 2'h0;
    localparam logic [13:0] OP_RETURN     = 14'h0008;
    localparam logic [13:0] OP_RETURN_FROM_INTERRUPT     = 14'h0009;
    localparam logic [13:0] OP_CALL_VIA_ACCUMULATOR      = 14'h000a;
    localparam logic [13:0] OP_BRW        = 14'h000b;
    localparam logic [2:0]  OP_CALL       = 3'h4;
    localparam logic [2:0]  OP_JUMP       = 3'h5;
    localparam logic [4:0]  OP_BRA        = 5'h19;
    localparam logic [5:0]  OP_RETURN_WITH_LITERAL      = 6'h34;
    localparam logic [5:0]  OP_DECSKIP    = 6'h0b;
    localparam logic [5:0]  OP_INCSKIP    = 6'h0f;
    localparam logic [3:0]  OP_BCLR       = 4'h4;
    localparam logic [3:0]  OP_BSET       = 4'h5;
    localparam logic [3:0]  OP_BSKIPC     = 4'h6;
    localparam logic [3:0]  OP_BSKIPS     = 4'h7;
    localparam logic [8:0]  OP_PTR_SHORT  = 9'h000;
    localparam logic [6:0]  OP_PTR_LONG   = 7'h7e;
    localparam logic [6:0]  OP_CTRL_GRP   = 7'h00;
    localparam logic [11:0] OP_CLRW       = 12'h040;
    localparam logic [1:0]  MSB_LIT       = 2'h3;
    localparam logic [1:0]  MSB_BYTE      = 2'h0;
    localparam logic [1:0]  MSB_BIT       = 2'h1;

    typedef enum logic [1:0]
    {
        FMT_BYTE = 2'b00,
        FMT_BIT  = 2'b01,
        FMT_LIT  = 2'b10
    } idt_fmt_t;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_STALL = 4'b0010,
        ST_EXEC  = 4'b0100,
        ST_FLUSH = 4'b1000
    } idt_state_t;
endpackage

// [idt_phase_gen.sv]
`timescale 1ns/10ps
module idt_phase_gen
    import idt_pkg::*;
#(
    parameter int PHASES = OSC_PER_CYC
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    output logic [PHASES-1:0]      phase_strobe,
    output logic                   cyc_end
);
    localparam int CW = $clog2(PHASES);
    localparam logic [CW-1:0] LAST = CW'(PHASES - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    // four oscillator periods make one instruction cycle
    always_comb
    begin
        if (cnt_reg == LAST)
            cnt_next = '0;
        else
            cnt_next = cnt_reg + CW'(1);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    genvar i;
    generate
        for (i = 0; i < PHASES; i++)
        begin : g_ph
            assign phase_strobe[i] = (cnt_reg == CW'(i));
        end
    endgenerate

    assign cyc_end = (cnt_reg == LAST);
endmodule

// [idt_core_timing.sv]
`timescale 1ns/10ps
module idt_core_timing
    import idt_pkg::*;
#(
    parameter logic [6:0] IND0_ADDR = 7'h00,
    parameter logic [6:0] IND1_ADDR = 7'h01
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic [INSTR_W-1:0]     instr_word,
    input  wire logic                   instr_valid,
    input  wire logic [1:0]             ptr_msb,
    input  wire logic [DATA_W-1:0]      file_rd_data,
    input  wire logic [DATA_W-1:0]      alu_result,
    output logic                        instr_ack,
    output logic [1:0]                  fmt_class,
    output logic [FILE_ADDR_W-1:0]      file_addr,
    output logic [2:0]                  bit_num,
    output logic [LIT_W-1:0]            literal,
    output logic                        dest_sel,
    output logic                        ptr_index,
    output logic [1:0]                  pointer_mode_field,
    output logic [DATA_W-1:0]           operand,
    output logic [DATA_W-1:0]           wr_data,
    output logic                        file_rd_en,
    output logic                        file_wr_en,
    output logic                        w_wr_en,
    output logic                        exec_nop,
    output logic                        pc_change,
    output logic [1:0]                  cycles_used,
    output logic [OSC_PER_CYC-1:0]      phase_strobe
);
    logic               rst_meta_reg;
    logic               rst_sync_reg;
    logic               cyc_end;
    idt_state_t         state_reg;
    logic [13:0]        instr_reg;
    logic [7:0]         operand_reg;
    logic [7:0]         wr_data_reg;
    logic               skip_reg;
    logic [1:0]         cyc_reg;
    logic               extra_in;
    logic               load;
    logic               flow;
    logic               st_exec;

    // decoded view of the held word
    idt_fmt_t           fmt;
    logic               is_callx;
    logic               is_ret;
    logic               is_jump;
    logic               is_bra;
    logic               is_skipf;
    logic               is_bskip;
    logic               is_bclr;
    logic               is_bset;
    logic               is_ptr_s;
    logic               is_ptr_l;
    logic               is_clrw;
    logic               lit_w;
    logic               reads_file;
    logic               writes_file;
    logic               writes_w;
    logic               two_cyc;
    logic               bit_val;
    logic [7:0]         bit_mask;
    logic [7:0]         bit_set_val;
    logic [7:0]         bit_clr_val;

    // release reset through two flops
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    idt_phase_gen #(
        .PHASES       (OSC_PER_CYC)
    ) u_phase (
        .sys_clk      (sys_clk),
        .rst_n        (rst_sync_reg),
        .phase_strobe (phase_strobe),
        .cyc_end      (cyc_end)
    );

    // indirect reference test on the incoming word
    function automatic logic ind_extra(input logic [13:0] w, input logic [1:0] msb);
        logic ref_ind;
        logic sel;
        ref_ind = 1'b0;
        sel     = 1'b0;
        if (w[13:7] == OP_PTR_LONG)
        begin
            ref_ind = 1'b1;
            sel     = w[PTR_IDX_LONG];
        end
        else if (w[13:5] == OP_PTR_SHORT && w[4])
        begin
            ref_ind = 1'b1;
            sel     = w[PTR_IDX_SHORT];
        end
        else if ((w[13:12] == MSB_BYTE && w[13:7] != OP_CTRL_GRP) || w[13:12] == MSB_BIT)
        begin
            if (w[13:2] != OP_CLRW && (w[6:0] == IND0_ADDR || w[6:0] == IND1_ADDR))
            begin
                ref_ind = 1'b1;
                sel     = (w[6:0] == IND1_ADDR);
            end
        end
        return ref_ind && msb[sel];
    endfunction

    assign extra_in = ind_extra(instr_word, ptr_msb);

    // format classification and operation groups
    always_comb
    begin
        is_callx = (instr_reg[13:11] == OP_CALL) || (instr_reg == OP_CALL_VIA_ACCUMULATOR);
        is_ret   = (instr_reg == OP_RETURN) || (instr_reg == OP_RETURN_FROM_INTERRUPT)
                   || (instr_reg[13:8] == OP_RETURN_WITH_LITERAL);
        is_jump  = (instr_reg[13:11] == OP_JUMP);
        is_bra   = (instr_reg[13:9] == OP_BRA) || (instr_reg == OP_BRW);
        is_skipf = (instr_reg[13:8] == OP_DECSKIP) || (instr_reg[13:8] == OP_INCSKIP);
        is_bskip = (instr_reg[13:10] == OP_BSKIPC) || (instr_reg[13:10] == OP_BSKIPS);
        is_bclr  = (instr_reg[13:10] == OP_BCLR);
        is_bset  = (instr_reg[13:10] == OP_BSET);
        is_ptr_s = (instr_reg[13:5] == OP_PTR_SHORT) && instr_reg[4];
        is_ptr_l = (instr_reg[13:7] == OP_PTR_LONG);
        // low two bits of the clear-W form ignored
        is_clrw  = (instr_reg[13:2] == OP_CLRW);
        if (instr_reg[13:12] == MSB_BIT)
            fmt = FMT_BIT;
        else if (instr_reg[13:12] == MSB_BYTE && instr_reg[13:7] != OP_CTRL_GRP)
            fmt = FMT_BYTE;
        else
            fmt = FMT_LIT;
    end

    // literal ops that load the working register
    always_comb
    begin
        lit_w = 1'b0;
        if (instr_reg[13:12] == MSB_LIT)
        begin
            case (instr_reg[11:8])
                4'h0, 4'h4, 4'h8, 4'h9, 4'ha, 4'hc, 4'he:
                    lit_w = 1'b1;
                default:
                    lit_w = 1'b0;
            endcase
        end
    end

    // read-modify-write steering
    always_comb
    begin
        reads_file  = (fmt == FMT_BIT) || (fmt == FMT_BYTE && !is_clrw);
        writes_file = 1'b0;
        writes_w    = lit_w;
        if (fmt == FMT_BYTE)
        begin
            writes_file = instr_reg[DEST_POS];
            writes_w    = !instr_reg[DEST_POS];
        end
        else if (is_bclr || is_bset)
            writes_file = 1'b1;
    end

    // per-bit select, set and clear images of the operand
    genvar b;
    generate
        for (b = 0; b < DATA_W; b++)
        begin : g_bit
            assign bit_mask[b]    = (instr_reg[9:7] == 3'(b));
            assign bit_set_val[b] = file_rd_data[b] | bit_mask[b];
            assign bit_clr_val[b] = file_rd_data[b] & ~bit_mask[b];
        end
    endgenerate

    assign bit_val  = |(file_rd_data & bit_mask);
    assign two_cyc  = is_callx || is_ret || is_jump || is_bra;
    assign st_exec  = (state_reg == ST_EXEC);
    assign flow     = two_cyc || skip_reg;
    assign load     = cyc_end && instr_valid
                      && (state_reg == ST_IDLE || state_reg == ST_FLUSH || (st_exec && !flow));

    // instruction sequencing at cycle boundaries
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            state_reg <= ST_IDLE;
        else if (cyc_end)
        begin
            case (state_reg)
                ST_IDLE, ST_FLUSH:
                begin
                    if (!instr_valid)
                        state_reg <= ST_IDLE;
                    else if (extra_in)
                        state_reg <= ST_STALL;
                    else
                        state_reg <= ST_EXEC;
                end
                ST_STALL:
                    state_reg <= ST_EXEC;
                ST_EXEC:
                begin
                    if (flow)
                        state_reg <= ST_FLUSH;
                    else if (!instr_valid)
                        state_reg <= ST_IDLE;
                    else if (extra_in)
                        state_reg <= ST_STALL;
                    else
                        state_reg <= ST_EXEC;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // whole fourteen-bit word latched
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            instr_reg <= INSTR_RST;
        else if (load)
            instr_reg <= instr_word;
    end

    // cycles spent on the current instruction
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            cyc_reg <= CYC_RST;
        else if (load)
            cyc_reg <= 2'h1;
        else if (cyc_end && (state_reg == ST_STALL || (st_exec && flow)))
            cyc_reg <= cyc_reg + 2'h1;
    end

    // operand read, result formed mid-cycle
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            operand_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end
        else if (st_exec && phase_strobe[PH_MODIFY])
        begin
            operand_reg <= file_rd_data;
            if (is_bset)
                wr_data_reg <= bit_set_val;
            else if (is_bclr)
                wr_data_reg <= bit_clr_val;
            else
                wr_data_reg <= alu_result;
        end
    end

    // skip condition resolved during modify phase
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            skip_reg <= 1'b0;
        else if (load)
            skip_reg <= 1'b0;
        else if (st_exec && phase_strobe[PH_MODIFY])
        begin
            if (is_skipf)
                skip_reg <= (alu_result == 8'h00);
            else if (is_bskip)
                skip_reg <= (bit_val == instr_reg[10]);
            else
                skip_reg <= 1'b0;
        end
    end

    // operand field extraction
    always_comb
    begin
        file_addr          = instr_reg[6:0] & FILE_ADDR_MAX;
        bit_num            = instr_reg[9:7];
        dest_sel           = (fmt == FMT_BYTE) && instr_reg[DEST_POS];
        ptr_index          = is_ptr_l ? instr_reg[PTR_IDX_LONG] : instr_reg[PTR_IDX_SHORT];
        pointer_mode_field = is_ptr_s ? instr_reg[1:0] : 2'h0;
        if (is_callx || is_jump)
            literal = instr_reg[10:0];
        else if (instr_reg[13:9] == OP_BRA)
            literal = {2'h0, instr_reg[8:0]};
        else if (is_ptr_l)
            literal = {5'h00, instr_reg[5:0]};
        else
            literal = {3'h0, instr_reg[7:0]};
    end

    assign fmt_class   = fmt;
    assign operand     = operand_reg;
    assign wr_data     = wr_data_reg;
    assign cycles_used = cyc_reg;
    assign instr_ack   = load;
    assign file_rd_en  = st_exec && phase_strobe[PH_READ] && reads_file;
    assign file_wr_en  = st_exec && phase_strobe[PH_WRITE] && writes_file;
    assign w_wr_en     = st_exec && phase_strobe[PH_WRITE] && writes_w;
    assign exec_nop    = (state_reg != ST_EXEC);
    assign pc_change   = st_exec && cyc_end && flow;
endmodule

// [idt_core_monitor.sv]
`timescale 1ns/10ps
module idt_core_monitor
    import idt_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   rst_n,
    input wire logic [INSTR_W-1:0]     instr_word,
    input wire logic                   instr_ack,
    input wire logic [1:0]             fmt_class,
    input wire logic [FILE_ADDR_W-1:0] file_addr,
    input wire logic [2:0]             bit_num,
    input wire logic                   dest_sel,
    input wire logic                   file_rd_en,
    input wire logic                   file_wr_en,
    input wire logic                   w_wr_en,
    input wire logic                   exec_nop,
    input wire logic                   pc_change,
    input wire logic [OSC_PER_CYC-1:0] phase_strobe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_ack_cycle_end:
        assert property (instr_ack |-> phase_strobe[3]) else $error("ack off cycle end");
    a_phase_order:
        assert property (phase_strobe[1] |=> phase_strobe[2] ##1 phase_strobe[3] ##1 phase_strobe[0])
        else $error("phase order");
    a_fmt_sort:
        assert property (instr_ack |=> fmt_class == (($past(instr_word[13]) || $past(instr_word[13:7]) == 7'h00) ?
            2'b10 : {1'b0, $past(instr_word[12])})) else $error("format class");
    a_byte_fields:
        assert property (instr_ack && instr_word[13:12] == 2'b00 && instr_word[13:7] != 7'h00 |=>
            file_addr == $past(instr_word[6:0]) && dest_sel == $past(instr_word[7])) else $error("byte fields");
    a_bit_select:
        assert property (instr_ack && instr_word[13:12] == 2'b01 |=> bit_num == $past(instr_word[9:7])
            && file_addr == $past(instr_word[6:0])) else $error("bit fields");
    a_read_phase:
        assert property (file_rd_en |-> phase_strobe[1] && !exec_nop) else $error("read phase");
    a_rmw_order:
        assert property (file_wr_en |-> phase_strobe[3] && $past(file_rd_en, 2)) else $error("write without read");
    a_dest_file:
        assert property (file_wr_en && fmt_class == 2'b00 |-> dest_sel) else $error("file write with d0");
    a_dest_w:
        assert property (w_wr_en |-> phase_strobe[3] && fmt_class != 2'b01 && !(fmt_class == 2'b00 && dest_sel))
        else $error("w write misdirected");
    a_flow_flush:
        assert property (pc_change |-> phase_strobe[3] ##1 exec_nop [*4]) else $error("flow cycle not nop");

    c_flow: cover property (pc_change);
    c_stall: cover property (instr_ack ##1 exec_nop);
    c_file_wr: cover property (file_wr_en);
endmodule

bind idt_core_timing idt_core_monitor u_mon
(
    .sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word), .instr_ack(instr_ack), .fmt_class(fmt_class),
    .file_addr(file_addr), .bit_num(bit_num), .dest_sel(dest_sel), .file_rd_en(file_rd_en),
    .file_wr_en(file_wr_en), .w_wr_en(w_wr_en), .exec_nop(exec_nop), .pc_change(pc_change),
    .phase_strobe(phase_strobe)
);

// [idt_prog_mem.sv]
`timescale 1ns/10ps
module idt_prog_mem
    import idt_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              instr_ack,
    input  wire logic              slow,
    output logic [INSTR_W-1:0]     instr_word,
    output logic                   instr_valid
);
    logic [INSTR_W-1:0] q[$];
    logic               taken = 1'b0;
    int                 hold_off = 0;

    task automatic push(input logic [INSTR_W-1:0] w);
        q.push_back(w);
    endtask

    initial
    begin
        instr_word = 14'h0000;
        instr_valid = 1'b0;
    end
    always @(negedge sys_clk)
        taken = instr_ack && instr_valid;
    // word held until an edge sees ack; released bus toggles
    always @(posedge sys_clk)
    begin
        #2;
        if (taken)
        begin
            void'(q.pop_front());
            hold_off = slow ? 4 : 0;
        end
        if (q.size() > 0 && hold_off == 0)
        begin
            instr_word = q[0];
            instr_valid = 1'b1;
        end
        else
        begin
            instr_valid = 1'b0;
            instr_word = ~instr_word;
        end
        if (hold_off > 0)
            hold_off--;
    end
endmodule

// [instruction_decode_timing_test.sv]
`timescale 1ns/10ps
module instruction_decode_timing_test
    import idt_pkg::*;
();
    logic                   sys_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   slow = 1'b0;
    logic                   took = 1'b0;
    logic                   fchk = 1'b0;
    logic                   gap_ok = 1'b0;
    logic [1:0]             ptr_msb = 2'h0;
    logic [1:0]             pm_v = 2'h0;
    logic [DATA_W-1:0]      file_rd_data = 8'h00;
    logic [DATA_W-1:0]      alu_result = 8'h00;
    logic [INSTR_W-1:0]     cur = 14'h0000;
    logic [INSTR_W-1:0]     instr_word;
    logic                   instr_valid, instr_ack, dest_sel, ptr_index;
    logic [1:0]             fmt_class, pointer_mode_field;
    logic [FILE_ADDR_W-1:0] file_addr;
    logic [LIT_W-1:0]       literal;
    logic [DATA_W-1:0]      operand, wr_data;
    logic [1:0]             cycles_used;
    logic [31:0]            seed = 32'h00014623;
    int                     error_cnt = 0;
    int                     checked = 0;
    int                     gap = 0;
    int                     cyc = 0;
    logic [13:0]            dir_w [26] = '{14'h07a5, 14'h0725, 14'h0ba0, 14'h0f20, 14'h1192, 14'h17ff, 14'h1801,
        14'h1e80, 14'h2123, 14'h2abc, 14'h0008, 14'h0009, 14'h000a, 14'h000b, 14'h3455, 14'h3321, 14'h30a5,
        14'h0100, 14'h0103, 14'h0080, 14'h0081, 14'h0016, 14'h0011, 14'h3f45, 14'h0000, 14'h0b81};

    function automatic logic [13:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[13:0];
    endfunction

    function automatic int cyc_of(input logic [13:0] w, input logic [1:0] pm, input logic [7:0] fd,
                                  input logic [7:0] ar);
        int n;
        n = 1;
        if (w[13:12] == 2'b10 || w[13:9] == 5'h19 || w[13:8] == 6'h34 || (w >= 14'h0008 && w <= 14'h000b))
            n = 2;
        if (((w[13:8] == 6'h0b || w[13:8] == 6'h0f) && ar == 8'h00) ||
            (w[13:11] == 3'b011 && fd[w[9:7]] == w[10]))
            n = 2;
        if ((!w[13] && w[13:7] != 7'h00 && w[6:1] == 6'h00 && w[13:2] != 12'h040 && pm[w[0]]) ||
            (w[13:4] == 10'h001 && pm[w[2]]) || (w[13:7] == 7'h7e && pm[w[6]]))
            n++;
        return n;
    endfunction

    function automatic logic [7:0] exp_wr(input logic [13:0] w, input logic [7:0] fd, input logic [7:0] ar);
        logic [7:0] m;
        m = 8'h01 << w[9:7];
        if (w[13:11] != 3'b010)
            return ar;
        return w[10] ? (fd | m) : (fd & ~m);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    idt_prog_mem pm
    (
        .sys_clk(sys_clk), .instr_ack(instr_ack), .slow(slow), .instr_word(instr_word), .instr_valid(instr_valid)
    );

    idt_core_timing dut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word), .instr_valid(instr_valid), .ptr_msb(ptr_msb),
        .file_rd_data(file_rd_data), .alu_result(alu_result), .instr_ack(instr_ack), .fmt_class(fmt_class),
        .file_addr(file_addr), .bit_num(), .literal(literal), .dest_sel(dest_sel), .ptr_index(ptr_index),
        .pointer_mode_field(pointer_mode_field), .operand(operand), .wr_data(wr_data), .file_rd_en(),
        .file_wr_en(), .w_wr_en(), .exec_nop(), .pc_change(), .cycles_used(cycles_used), .phase_strobe()
    );

    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            stop_test();
        end
        #2;
        if (took)
        begin
            took = 1'b0;
            void'(rnd());
            file_rd_data = seed[7:0];
            alu_result = seed[18] ? 8'h00 : seed[15:8];
            ptr_msb = seed[17:16];
        end
    end

    always @(negedge sys_clk)
    begin
        gap++;
        if (fchk)
        begin
            fchk = 1'b0;
            if (cur[13:12] == 2'b11 && cur[13:8] != 6'h3f)
                check(16'(literal[7:0]), 16'(cur[7:0]));
            if (cur[13:12] == 2'b10)
                check(16'(literal), 16'(cur[10:0]));
            if (cur[13:4] == 10'h001)
                check(16'({ptr_index, pointer_mode_field}), 16'(cur[2:0]));
            if (cur[13:7] == 7'h7e)
                check(16'(ptr_index), 16'(cur[6]));
        end
        if (instr_ack === 1'b1)
        begin
            if (gap_ok)
                check(16'(gap), 16'(4 * cyc_of(cur, pm_v, file_rd_data, alu_result)));
            if (gap_ok)
                check(16'(cycles_used), 16'(cyc_of(cur, pm_v, file_rd_data, alu_result)));
            if (gap_ok && !cur[13] && cur[13:7] != 7'h00 && cur[13:2] != 12'h040)
                check({operand, wr_data}, {file_rd_data, exp_wr(cur, file_rd_data, alu_result)});
            cur = instr_word;
            pm_v = ptr_msb;
            gap = 0;
            fchk = 1'b1;
            took = 1'b1;
            gap_ok = !slow;
        end
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        #2;
        rst_n = 1'b1;
        foreach (dir_w[i])
            pm.push(dir_w[i]);
        repeat (150)
            pm.push(rnd());
        while (pm.q.size() > 0)
            @(posedge sys_clk);
        slow = 1'b1;
        gap_ok = 1'b0;
        repeat (8)
            pm.push(rnd());
        while (pm.q.size() > 0)
            @(posedge sys_clk);
        repeat (24) @(posedge sys_clk);
        stop_test();
    end
endmodule
